// ---- core/ncf_front_end.sv ----
// per-channel oscillator input front-end control with apb registers
//
// How it works
// - ctrl bit 0 bypasses the oscillator
// - bypass: port a to i, port b to q
// - ctrl bit 1 enables phase dither
// - ctrl bit 2 amplitude dither, independent of phase
// - ctrl bit 3 clears accumulator with each hop transfer
// - phase offset always applies; else accumulator continues
// - each channel picks own qualifier mode
// - mode 00 latch while high, zeros while low
// - mode 00 oscillator keeps advancing while blanked
// - mode 00 downstream runs while qualifier high
// - mode 01 latch only while high, halt oscillator
// - mode 01 downstream runs every master clock
// - mode 10 latch once after rising qualifier
// - mode 11 latch once after falling qualifier
// - modes 10/11 advance oscillator per latched sample
// - modes 10/11 downstream runs every clock
// - ctrl bit 6 picks port b, else a
// - ctrl bits 8:7 pick sync pin a..d
// - any sync pin may serve any channel
// - hop loads 16-bit hold-off, counts, then transfers
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "ncf_defs.svh"
module ncf_front_end (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [13:0] wideband_port_a_samples,
  input  wire logic [13:0] wideband_port_b_samples,
  input  wire logic [2:0]  port_a_gain_range,
  input  wire logic [2:0]  port_b_gain_range,
  input  wire logic        port_a_sample_qualifier,
  input  wire logic        port_b_sample_qualifier,
  input  wire logic        sync_pin_first,
  input  wire logic        sync_pin_second,
  input  wire logic        sync_pin_third,
  input  wire logic        sync_pin_fourth,
  input  wire logic        sleep_exit,
  output logic      [13:0] path_i_sample,
  output logic      [13:0] path_q_sample,
  output logic      [2:0]  path_gain_range,
  output logic             sample_latched,
  output logic             backend_run,
  output logic             osc_advance,
  output logic             osc_bypass,
  output logic             phase_dither_en,
  output logic             amp_dither_en,
  output logic             acc_clear,
  output logic             freq_transfer
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [8:0]  ctrl_ff;        // channel control word
  logic [15:0] holdoff_ff;     // hold-off reload value
  logic [15:0] hold_cnt_ff;    // hold-off down counter
  ncf_pkg::ncf_hold_t hold_st_ff; // hold-off state
  logic        q_prev_ff;      // previous qualifier level
  logic        q_pending_ff;   // edge seen, latch on next clock
  logic [13:0] a_s1_ff, a_s2_ff, b_s1_ff, b_s2_ff;  // sample synchronisers
  logic [2:0]  ga_s1_ff, ga_s2_ff, gb_s1_ff, gb_s2_ff; // gain synchronisers
  logic [1:0]  qa_s_ff, qb_s_ff;  // qualifier synchronisers
  logic [3:0]  sy_s1_ff, sy_s2_ff; // sync pin synchronisers
  logic [1:0]  sx_s_ff;        // sleep exit synchroniser
  logic        sync_prev_ff;   // previous selected sync level
  logic        sleep_prev_ff;  // previous sleep exit level

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic ncf_hit(input logic [11:0] a, input logic [11:0] r);
    ncf_hit = (a == r);
  endfunction : ncf_hit

  ncf_pkg::ncf_qmode_t qmode;  // current qualifier mode
  logic       use_b;           // port b selected
  logic [1:0] sync_sel;        // sync pin index
  logic       q_now;           // selected synchronised qualifier
  logic       sync_now;        // selected synchronised sync pin
  logic       hop_evt;         // rising edge on sync or sleep exit
  logic       apb_wr;          // write access phase
  logic       apb_rd;          // read access phase
  logic       mapped;          // address in map

  assign qmode    = ncf_pkg::ncf_qmode_t'(ctrl_ff[`NCF_CTRL_QMODE_LO +: 2]);
  assign use_b    = ctrl_ff[`NCF_CTRL_PORTSEL];
  assign sync_sel = ctrl_ff[`NCF_CTRL_SYNC_LO +: 2];
  assign q_now    = use_b ? qb_s_ff[1] : qa_s_ff[1];
  assign sync_now = sy_s2_ff[sync_sel];
  assign hop_evt  = (sync_now & ~sync_prev_ff) | (sx_s_ff[1] & ~sleep_prev_ff);
  assign apb_wr   = psel & penable & pwrite;
  assign apb_rd   = psel & penable & ~pwrite;
  assign mapped   = ncf_hit(paddr, `NCF_ADDR_CTRL) | ncf_hit(paddr, `NCF_ADDR_HOLDOFF)
                  | ncf_hit(paddr, `NCF_ADDR_STATUS);

  // ----------------------------------------------------------------
  // input synchronisers (two flops before any logic)
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_s1_ff  <= 14'h0000;
      a_s2_ff  <= 14'h0000;
      b_s1_ff  <= 14'h0000;
      b_s2_ff  <= 14'h0000;
      ga_s1_ff <= 3'h0;
      ga_s2_ff <= 3'h0;
      gb_s1_ff <= 3'h0;
      gb_s2_ff <= 3'h0;
      qa_s_ff  <= 2'h0;
      qb_s_ff  <= 2'h0;
      sy_s1_ff <= 4'h0;
      sy_s2_ff <= 4'h0;
      sx_s_ff  <= 2'h0;
    end else begin
      a_s1_ff  <= wideband_port_a_samples;
      a_s2_ff  <= a_s1_ff;
      b_s1_ff  <= wideband_port_b_samples;
      b_s2_ff  <= b_s1_ff;
      ga_s1_ff <= port_a_gain_range;
      ga_s2_ff <= ga_s1_ff;
      gb_s1_ff <= port_b_gain_range;
      gb_s2_ff <= gb_s1_ff;
      qa_s_ff  <= {qa_s_ff[0], port_a_sample_qualifier};
      qb_s_ff  <= {qb_s_ff[0], port_b_sample_qualifier};
      sy_s1_ff <= {sync_pin_fourth, sync_pin_third, sync_pin_second, sync_pin_first};
      sy_s2_ff <= sy_s1_ff;
      sx_s_ff  <= {sx_s_ff[0], sleep_exit};
    end
  end

  // ----------------------------------------------------------------
  // apb slave: zero wait, error on unmapped address
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff    <= `NCF_CTRL_RESET;
      holdoff_ff <= `NCF_HOLDOFF_RESET;
    end else if (apb_wr) begin
      // control word written in the access phase
      if (ncf_hit(paddr, `NCF_ADDR_CTRL))
        ctrl_ff <= pwdata[8:0];
      if (ncf_hit(paddr, `NCF_ADDR_HOLDOFF))
        holdoff_ff <= pwdata[15:0];
    end
  end

  // read data and answer flags registered in setup for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;  // no wait state: ready in first access cycle
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite) begin
        // read mux; unmapped reads return zero
        if (ncf_hit(paddr, `NCF_ADDR_CTRL))
          prdata <= {23'h00_0000, ctrl_ff};
        else if (ncf_hit(paddr, `NCF_ADDR_HOLDOFF))
          prdata <= {16'h0000, holdoff_ff};
        else if (ncf_hit(paddr, `NCF_ADDR_STATUS))
          prdata <= {12'h000, hold_cnt_ff, 1'b0, hold_st_ff, q_now};
        else
          prdata <= 32'h0000_0000;
      end else if (apb_rd) begin
        prdata <= prdata;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // qualifier edge tracking
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_prev_ff    <= 1'b0;
      q_pending_ff <= 1'b0;
    end else begin
      q_prev_ff <= q_now;
      // an edge of the chosen polarity arms one latch on the next clock
      case (qmode)
        ncf_pkg::NCF_Q_RISE: q_pending_ff <= q_now & ~q_prev_ff;
        ncf_pkg::NCF_Q_FALL: q_pending_ff <= ~q_now & q_prev_ff;
        default:             q_pending_ff <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sample latch, oscillator advance and downstream run per mode
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      path_i_sample   <= 14'h0000;
      path_q_sample   <= 14'h0000;
      path_gain_range <= 3'h0;
      sample_latched  <= 1'b0;
      osc_advance     <= 1'b0;
      backend_run     <= 1'b0;
    end else begin
      sample_latched <= 1'b0;
      osc_advance    <= 1'b0;
      backend_run    <= 1'b1;
      case (qmode)
        ncf_pkg::NCF_Q_BLANK: begin
          osc_advance <= 1'b1;
          backend_run <= q_now;
          if (q_now) begin
            sample_latched <= 1'b1;
            if (ctrl_ff[`NCF_CTRL_BYPASS]) begin
              path_i_sample <= a_s2_ff;
              path_q_sample <= b_s2_ff;
            end else begin
              path_i_sample <= use_b ? b_s2_ff : a_s2_ff;
              path_q_sample <= 14'h0000;
            end
            path_gain_range <= use_b ? gb_s2_ff : ga_s2_ff;
          end else begin
            // blanked input reads as zero
            path_i_sample <= 14'h0000;
            path_q_sample <= 14'h0000;
          end
        end
        ncf_pkg::NCF_Q_GATE: begin
          // downstream keeps running on every master clock
          if (q_now) begin
            sample_latched <= 1'b1;
            osc_advance    <= 1'b1;
            path_i_sample  <= ctrl_ff[`NCF_CTRL_BYPASS] ? a_s2_ff : (use_b ? b_s2_ff : a_s2_ff);
            path_q_sample  <= ctrl_ff[`NCF_CTRL_BYPASS] ? b_s2_ff : 14'h0000;
            path_gain_range <= use_b ? gb_s2_ff : ga_s2_ff;
          end
        end
        ncf_pkg::NCF_Q_RISE, ncf_pkg::NCF_Q_FALL: begin
          // one latch per armed edge; downstream runs every clock
          if (q_pending_ff) begin
            sample_latched <= 1'b1;
            osc_advance    <= 1'b1;
            path_i_sample  <= ctrl_ff[`NCF_CTRL_BYPASS] ? a_s2_ff : (use_b ? b_s2_ff : a_s2_ff);
            path_q_sample  <= ctrl_ff[`NCF_CTRL_BYPASS] ? b_s2_ff : 14'h0000;
            path_gain_range <= use_b ? gb_s2_ff : ga_s2_ff;
          end
        end
        default: begin
          backend_run <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // oscillator option outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_bypass      <= 1'b0;
      phase_dither_en <= 1'b0;
      amp_dither_en   <= 1'b0;
    end else begin
      osc_bypass      <= ctrl_ff[`NCF_CTRL_BYPASS];
      phase_dither_en <= ctrl_ff[`NCF_CTRL_PDITH];
      amp_dither_en   <= ctrl_ff[`NCF_CTRL_ADITH];
    end
  end

  // ----------------------------------------------------------------
  // hop hold-off counter and frequency transfer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_st_ff    <= ncf_pkg::NCF_H_IDLE;
      hold_cnt_ff   <= 16'h0000;
      sync_prev_ff  <= 1'b0;
      sleep_prev_ff <= 1'b0;
      acc_clear     <= 1'b0;
      freq_transfer <= 1'b0;
    end else begin
      sync_prev_ff  <= sync_now;
      sleep_prev_ff <= sx_s_ff[1];
      acc_clear     <= 1'b0;
      freq_transfer <= 1'b0;
      case (hold_st_ff)
        ncf_pkg::NCF_H_IDLE: begin
          if (hop_evt) begin
            hold_cnt_ff <= holdoff_ff;
            hold_st_ff  <= ncf_pkg::NCF_H_COUNT;
          end
        end
        ncf_pkg::NCF_H_COUNT: begin
          if (hold_cnt_ff == 16'h0000)
            hold_st_ff <= ncf_pkg::NCF_H_LOAD;
          else
            hold_cnt_ff <= hold_cnt_ff - 16'h0001;
        end
        ncf_pkg::NCF_H_LOAD: begin
          // clear pulses with the transfer; offset is untouched either way
          freq_transfer <= 1'b1;
          acc_clear     <= ctrl_ff[`NCF_CTRL_CLRHOP];
          hold_st_ff    <= ncf_pkg::NCF_H_IDLE;
        end
        default: hold_st_ff <= ncf_pkg::NCF_H_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_bypass_follows: assert property (osc_bypass == $past(ctrl_ff[0]))
    else $error("bypass wrong");
  a_bypass_quad: assert property (
    (ctrl_ff[0] && qmode == ncf_pkg::NCF_Q_BLANK && q_now) |=> path_q_sample == $past(b_s2_ff))
    else $error("q path wrong");
  a_gate_bypass: assert property (
    (ctrl_ff[0] && qmode == ncf_pkg::NCF_Q_GATE && q_now)
    |=> path_i_sample == $past(a_s2_ff) && path_q_sample == $past(b_s2_ff))
    else $error("gated bypass wrong");
  a_phase_dither: assert property (phase_dither_en == $past(ctrl_ff[1]))
    else $error("pdither wrong");
  a_amp_dither: assert property (amp_dither_en == $past(ctrl_ff[2]))
    else $error("adither wrong");
  a_clear_hop: assert property (
    (hold_st_ff == ncf_pkg::NCF_H_LOAD) |=> acc_clear == $past(ctrl_ff[3]) && freq_transfer)
    else $error("hop clear wrong");
  a_blank_zero: assert property (
    (qmode == ncf_pkg::NCF_Q_BLANK && !q_now) |=> path_i_sample == 14'h0000 && osc_advance)
    else $error("blank wrong");
  a_blank_run: assert property (
    (qmode == ncf_pkg::NCF_Q_BLANK) |=> backend_run == $past(q_now))
    else $error("blank run wrong");
  a_gate_halt: assert property (
    (qmode == ncf_pkg::NCF_Q_GATE && !q_now) |=> !osc_advance && !sample_latched && backend_run)
    else $error("gate wrong");
  a_rise_once: assert property (
    (qmode == ncf_pkg::NCF_Q_RISE && q_now && !q_prev_ff) ##1 (qmode == ncf_pkg::NCF_Q_RISE)
    |=> sample_latched ##1 !sample_latched)
    else $error("rise wrong");
  a_fall_once: assert property (
    (qmode == ncf_pkg::NCF_Q_FALL && !q_now && q_prev_ff) ##1 (qmode == ncf_pkg::NCF_Q_FALL)
    |=> sample_latched ##1 !sample_latched)
    else $error("fall wrong");
  a_edge_advance: assert property (
    (qmode inside {ncf_pkg::NCF_Q_RISE, ncf_pkg::NCF_Q_FALL}) |=> osc_advance == sample_latched)
    else $error("adv wrong");
  a_edge_run: assert property (
    (qmode inside {ncf_pkg::NCF_Q_RISE, ncf_pkg::NCF_Q_FALL}) |=> backend_run)
    else $error("edge run wrong");
  a_hop_load: assert property (
    (hold_st_ff == ncf_pkg::NCF_H_IDLE && hop_evt)
    |=> hold_st_ff == ncf_pkg::NCF_H_COUNT && hold_cnt_ff == $past(holdoff_ff))
    else $error("hop load wrong");
  a_holdoff_done: assert property (
    (hold_st_ff == ncf_pkg::NCF_H_COUNT && hold_cnt_ff == 16'h0000) |-> ##2 freq_transfer)
    else $error("holdoff wrong");

  c_hop: cover property (freq_transfer);
  c_rise: cover property (qmode == ncf_pkg::NCF_Q_RISE && sample_latched);
  c_fall: cover property (qmode == ncf_pkg::NCF_Q_FALL && sample_latched);
  c_bypass: cover property (osc_bypass && sample_latched);

endmodule : ncf_front_end
`default_nettype wire

// ---- core/ncf_defs.svh ----
// constants for the oscillator input front-end control block
`ifndef NCF_DEFS_SVH
`define NCF_DEFS_SVH
`define NCF_ADDR_CTRL      12'h088
`define NCF_ADDR_HOLDOFF   12'h084
`define NCF_ADDR_STATUS    12'h08c
`define NCF_CTRL_BYPASS    0
`define NCF_CTRL_PDITH     1
`define NCF_CTRL_ADITH     2
`define NCF_CTRL_CLRHOP    3
`define NCF_CTRL_QMODE_LO  4
`define NCF_CTRL_PORTSEL   6
`define NCF_CTRL_SYNC_LO   7
`define NCF_CTRL_RESET     9'h000
`define NCF_CTRL_MASK      32'h0000_01ff
`define NCF_HOLDOFF_RESET  16'h0000
`endif

// ---- core/ncf_pkg.sv ----
// types for the oscillator input front-end control block
package ncf_pkg;
  typedef enum logic [1:0] {
    NCF_Q_BLANK = 2'b00,
    NCF_Q_GATE  = 2'b01,
    NCF_Q_RISE  = 2'b10,
    NCF_Q_FALL  = 2'b11
  } ncf_qmode_t;
  typedef enum logic [1:0] {
    NCF_H_IDLE  = 2'b00,
    NCF_H_COUNT = 2'b01,
    NCF_H_LOAD  = 2'b11
  } ncf_hold_t;
endpackage : ncf_pkg

// ---- tb/ncf_adc_model.sv ----
// behavioural wideband converter that drives the front-end sample ports
`timescale 1ns/100ps
`default_nettype none
module ncf_adc_model (
  input  wire logic        pclk,    // master clock
  input  wire logic        presetn, // async reset, active low
  input  wire logic [13:0] cmd_a,   // next port a conversion
  input  wire logic [13:0] cmd_b,   // next port b conversion
  input  wire logic        cmd_qa,  // wanted port a qualifier level
  input  wire logic        cmd_qb,  // wanted port b qualifier level
  output logic      [13:0] adc_a,   // port a samples
  output logic      [13:0] adc_b,   // port b samples
  output logic      [2:0]  adc_ga,  // port a gain range
  output logic      [2:0]  adc_gb,  // port b gain range
  output logic             adc_qa,  // port a qualifier
  output logic             adc_qb   // port b qualifier
);
  // ----------------------------------------
  // converter output register
  // ----------------------------------------
  // gain range follows the top sample bits so each conversion is unique
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_a  <= 14'h0000;
      adc_b  <= 14'h0000;
      adc_ga <= 3'h0;
      adc_gb <= 3'h0;
      adc_qa <= 1'b0;
      adc_qb <= 1'b0;
    end else begin
      adc_a  <= cmd_a;
      adc_b  <= cmd_b;
      adc_ga <= cmd_a[13:11];
      adc_gb <= cmd_b[13:11];
      adc_qa <= cmd_qa;
      adc_qb <= cmd_qb;
    end
  end
endmodule : ncf_adc_model
`default_nettype wire

// ---- tb/tb_nco_input_front_end_control.sv ----
// self-checking bench for the oscillator input front-end control
`timescale 1ns/100ps
`default_nettype none
`include "ncf_defs.svh"
module tb_nco_input_front_end_control;
  // ----------------------------------------
  // stimulus and observation signals
  // ----------------------------------------
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [13:0] cmd_a = 14'h0000, cmd_b = 14'h0000, adc_a, adc_b, pi, pq, va, vb;
  logic [2:0] adc_ga, adc_gb, pg;
  logic cmd_qa = 0, cmd_qb = 0, adc_qa, adc_qb, lat, brun, adv, byp, pdi, adi, clr, ft, slp = 0;
  logic [3:0] sync_pins = 4'h0;
  logic [31:0] v, rd;
  logic er;
  int mismatches = 0, checks_done = 0, cyc = 0, n_lat = 0, n_adv = 0, n_ft = 0, n_clr = 0, n_brl = 0;
  int b_lat, b_adv, b_ft, b_clr, b_brl;
  always #5 pclk = ~pclk;
  ncf_adc_model adc_u (.pclk(pclk), .presetn(presetn), .cmd_a(cmd_a), .cmd_b(cmd_b), .cmd_qa(cmd_qa),
    .cmd_qb(cmd_qb), .adc_a(adc_a), .adc_b(adc_b), .adc_ga(adc_ga), .adc_gb(adc_gb), .adc_qa(adc_qa), .adc_qb(adc_qb));
  ncf_front_end dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wideband_port_a_samples(adc_a), .wideband_port_b_samples(adc_b), .port_a_gain_range(adc_ga),
    .port_b_gain_range(adc_gb), .port_a_sample_qualifier(adc_qa), .port_b_sample_qualifier(adc_qb),
    .sync_pin_first(sync_pins[0]), .sync_pin_second(sync_pins[1]), .sync_pin_third(sync_pins[2]),
    .sync_pin_fourth(sync_pins[3]), .sleep_exit(slp), .path_i_sample(pi), .path_q_sample(pq),
    .path_gain_range(pg), .sample_latched(lat), .backend_run(brun), .osc_advance(adv), .osc_bypass(byp),
    .phase_dither_en(pdi), .amp_dither_en(adi), .acc_clear(clr), .freq_transfer(ft));
  // ----------------------------------------
  // event counters and hang guard
  // ----------------------------------------
  // running tallies of pulses, so a window is judged by difference
  always @(posedge pclk) begin
    cyc   <= cyc + 1;
    n_lat <= n_lat + int'(lat === 1'b1);
    n_adv <= n_adv + int'(adv === 1'b1);
    n_ft  <= n_ft + int'(ft === 1'b1);
    n_clr <= n_clr + int'(clr === 1'b1);
    n_brl <= n_brl + int'(brun !== 1'b1);
    if (cyc == 6000) begin
      mismatches++;
      complete_run();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask : settle
  // one apb transfer: request held until pready is sampled high
  task automatic apb_xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) chk("pready", 32'(pready), 32'h0000_0001);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer
  task automatic apb_rd(input logic [11:0] a, input logic [31:0] exp, input logic eer);
    apb_xfer(a, 1'b0, 32'h0000_0000);
    chk("prdata", rd, exp);
    chk("pslverr", 32'(er), 32'(eer));
  endtask : apb_rd
  function automatic logic [31:0] ctl(input int m, input int p, input int s, input int by, input int cl);
    return {23'h0, s[1:0], p[0], m[1:0], cl[0], 2'h0, by[0]};
  endfunction : ctl
  function automatic logic [13:0] exp_i(input logic [31:0] c, input logic [13:0] a, input logic [13:0] b);
    return c[6] ? b : a;
  endfunction : exp_i
  task automatic snap();
    b_lat = n_lat;
    b_adv = n_adv;
    b_ft  = n_ft;
    b_clr = n_clr;
    b_brl = n_brl;
  endtask : snap
  task automatic sync_pulse(input int k);
    sync_pins <= 4'h1 << k;
    settle(4);
    sync_pins <= 4'h0;
  endtask : sync_pulse
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(30550));
    settle(2);
    presetn <= 1'b1;
    apb_rd(`NCF_ADDR_CTRL, 32'h0000_0000, 1'b0);
    apb_rd(12'h010, 32'h0000_0000, 1'b1);
    for (int i = 0; i < 8; i++) begin
      v = ($urandom() & 32'hffff_fff8) | 32'(i);
      apb_xfer(`NCF_ADDR_CTRL, 1'b1, v);
      apb_rd(`NCF_ADDR_CTRL, v & `NCF_CTRL_MASK, 1'b0);
      settle(2);
      chk("osc_bypass", 32'(byp), 32'(v[0]));
      chk("phase_dither_en", 32'(pdi), 32'(v[1]));
      chk("amp_dither_en", 32'(adi), 32'(v[2]));
    end
    // blanking mode: latch while high, zeros and free-running oscillator while low
    va = 14'($urandom());
    cmd_a  <= va;
    cmd_qa <= 1'b1;
    apb_xfer(`NCF_ADDR_CTRL, 1'b1, ctl(0, 0, 0, 0, 0));
    settle(8);
    chk("path_i", 32'(pi), 32'(exp_i(ctl(0, 0, 0, 0, 0), va, vb)));
    chk("path_q_nobypass", 32'(pq), 32'h0000_0000);
    chk("gain", 32'(pg), 32'(va[13:11]));
    chk("backend_run", 32'(brun), 32'h0000_0001);
    cmd_qa <= 1'b0;
    snap();
    settle(10);
    chk("adv_blank", 32'(n_adv - b_adv), 32'h0000_000a);
    chk("path_i_blank", 32'(pi), 32'h0000_0000);
    chk("brun_blank", 32'(brun), 32'h0000_0000);
    // gated mode: nothing latched, oscillator halted, back end running
    apb_xfer(`NCF_ADDR_CTRL, 1'b1, ctl(1, 0, 0, 0, 0));
    settle(4);
    snap();
    settle(10);
    chk("lat_gated", 32'(n_lat - b_lat), 32'h0000_0000);
    chk("adv_gated", 32'(n_adv - b_adv), 32'h0000_0000);
    chk("brun_gated", 32'(n_brl - b_brl), 32'h0000_0000);
    // edge modes: exactly one latch and one oscillator step per qualifier edge
    for (int m = 2; m < 4; m++) begin
      cmd_qa <= (m == 3);
      settle(6);
      apb_xfer(`NCF_ADDR_CTRL, 1'b1, ctl(m, 0, 0, 0, 0));
      settle(4);
      snap();
      va = 14'($urandom());
      cmd_a  <= va;
      cmd_qa <= (m == 2);
      settle(14);
      chk("lat_edge", 32'(n_lat - b_lat), 32'h0000_0001);
      chk("adv_edge", 32'(n_adv - b_adv), 32'h0000_0001);
      chk("brun_edge", 32'(n_brl - b_brl), 32'h0000_0000);
      chk("path_i_edge", 32'(pi), 32'(va));
    end
    // port b select in gated mode with port a qualifier low
    vb = 14'($urandom());
    cmd_b  <= vb;
    cmd_qb <= 1'b1;
    cmd_qa <= 1'b0;
    apb_xfer(`NCF_ADDR_CTRL, 1'b1, ctl(1, 1, 0, 0, 0));
    settle(8);
    chk("path_i_b", 32'(pi), 32'(exp_i(ctl(1, 1, 0, 0, 0), va, vb)));
    chk("gain_b", 32'(pg), 32'(vb[13:11]));
    chk("path_q_b", 32'(pq), 32'h0000_0000);
    // bypass: port a to in-phase, port b to quadrature
    cmd_qa <= 1'b1;
    apb_xfer(`NCF_ADDR_CTRL, 1'b1, ctl(1, 0, 0, 1, 0));
    settle(8);
    chk("bypass_i", 32'(pi), 32'(va));
    chk("bypass_q", 32'(pq), 32'(vb));
    // sync pin selection, hop transfer and clear-on-hop
    apb_xfer(`NCF_ADDR_HOLDOFF, 1'b1, 32'h0000_0003);
    for (int s = 0; s < 4; s++) begin
      apb_xfer(`NCF_ADDR_CTRL, 1'b1, ctl(1, 0, s, 0, s % 2));
      settle(4);
      snap();
      sync_pulse((s + 1) % 4);
      settle(30);
      chk("ft_other_pin", 32'(n_ft - b_ft), 32'h0000_0000);
      sync_pulse(s);
      settle(30);
      chk("ft_own_pin", 32'(n_ft - b_ft), 32'h0000_0001);
      chk("acc_clear", 32'(n_clr - b_clr), 32'(s % 2));
    end
    // a long hold-off delays the transfer
    apb_xfer(`NCF_ADDR_HOLDOFF, 1'b1, 32'h0000_0028);
    apb_rd(`NCF_ADDR_HOLDOFF, 32'h0000_0028, 1'b0);
    snap();
    sync_pulse(3);
    settle(20);
    chk("ft_early", 32'(n_ft - b_ft), 32'h0000_0000);
    settle(40);
    chk("ft_late", 32'(n_ft - b_ft), 32'h0000_0001);
    // status: idle hold-off, counter drained, port a qualifier high
    apb_rd(`NCF_ADDR_STATUS, 32'h0000_0001, 1'b0);
    // leaving sleep starts the same hold-off and transfer
    snap();
    slp <= 1'b1;
    settle(60);
    chk("ft_sleep", 32'(n_ft - b_ft), 32'h0000_0001);
    chk("clr_sleep", 32'(n_clr - b_clr), 32'h0000_0001);
    slp <= 1'b0;
    complete_run();
  end
endmodule : tb_nco_input_front_end_control
`default_nettype wire
